/* File: design/chain_spi_target.sv */
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

// What the serial link requires of this block and its master
// (RULE1) Packet is control, address, data bytes
// (RULE2) Sample input on eight rising clocks
// (RULE3) Select release after eight bits advances byte
// (RULE4) Master frames each byte with select
// (RULE5) Drive output only in read data byte
// (RULE6) Clock edge with select high resynchronises
// (RULE7) Abandoned packet leaves register unchanged
// (RULE8) Master repeats corrupted write after resync; the bench master does not repeat its abandoned write to address 8'h02
// (RULE9) Control bit 6 high means read
// (RULE10) Control bit 6 low means write
// (RULE11) Read ignores broadcast; only addressed answers
// (RULE12) Unimplemented address reads all zeros
// (RULE13) Unimplemented address write changes nothing
// (RULE14) Broadcast write updates every chained device
// (RULE15) Plain write updates only selected device
// (RULE16) Forward input bits unchanged except id
// (RULE17) Low four control bits zero select
// (RULE18) Decrement id serially with rippling borrow
// (RULE19) Master places id bits reversed
// (RULE20) Single device uses chain id zero
// (RULE21) Second byte address, third byte data
// (RULE22) Bytes shifted most significant bit first
module chain_spi_target (
    // System
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // Serial pins
    input  wire logic        i_sclk,
    input  wire logic        i_select_n,
    input  wire logic        i_mosi,
    output logic             o_miso,
    output logic             o_miso_oe_n,
    output logic             o_serial_forward_out,
    // Channel state and filter settings
    input  wire logic [7:0]  i_channel_status,
    output logic      [15:0] o_filter_mode,
    output logic      [15:0] o_filter_delay,
    // AXI4-Lite write
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    input  wire logic [7:0]  i_s_axi_awaddr,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    output logic      [1:0]  o_s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    input  wire logic [7:0]  i_s_axi_araddr,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready,
    output logic      [31:0] o_s_axi_rdata,
    output logic      [1:0]  o_s_axi_rresp
);

    // Synchronised pins and edges
    logic [2:0]                 pins_s;
    logic [7:0]                 status_s;
    logic                       sclk_s;
    logic                       nss_s;
    logic                       mosi_s;
    logic                       sclk_d;
    logic                       nss_d;
    logic                       sclk_rise;
    logic                       sclk_fall;
    logic                       nss_rise;
    logic                       nss_fall;

    // Serial state
    chain_spi_pkg::phase_t      phase;
    chain_spi_pkg::phase_t      next_phase;
    logic [3:0]                 bit_cnt;
    logic [3:0]                 next_bit_cnt;
    logic [7:0]                 shift_in;
    logic [7:0]                 next_shift_in;
    logic [7:0]                 ctrl_byte;
    logic [7:0]                 next_ctrl_byte;
    logic [7:0]                 tx_shift;
    logic [7:0]                 next_tx_shift;
    logic                       drive;
    logic                       next_drive;
    logic [7:0]                 mode0;
    logic [7:0]                 mode1;
    logic [7:0]                 dly0;
    logic [7:0]                 dly1;
    logic [7:0]                 next_mode0;
    logic [7:0]                 next_mode1;
    logic [7:0]                 next_dly0;
    logic [7:0]                 next_dly1;
    logic                       lost_flag;
    logic                       next_lost_flag;
    logic [7:0]                 addr_byte;
    logic [7:0]                 next_addr_byte;
    logic                       is_read;
    logic                       selected;

    // Bus state
    logic                       enable;
    logic                       next_enable;
    logic                       next_bvalid;
    logic [1:0]                 next_bresp;
    logic                       next_rvalid;
    logic [31:0]                next_rdata;
    logic [1:0]                 next_rresp;
    logic                       wr_go;
    logic                       clr_lost;

    // Pin and status synchronisers
    sync_2ff #(.W(3), .RST_VAL(chain_spi_pkg::PIN_SYNC_RST)) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_async   ({i_select_n, i_sclk, i_mosi}),
        .o_sync    (pins_s)
    );

    sync_2ff #(.W(8), .RST_VAL(8'h00)) u_status_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_async   (i_channel_status),
        .o_sync    (status_s)
    );

    // Edge detection on synchronised pins
    assign nss_s     = pins_s[2];
    assign sclk_s    = pins_s[1];
    assign mosi_s    = pins_s[0];
    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;
    assign nss_rise  = nss_s & ~nss_d;
    assign nss_fall  = ~nss_s & nss_d;

    // (RULE9) (RULE10) read or write decode
    assign is_read  = ctrl_byte[chain_spi_pkg::CTRL_READ_BIT];
    // (RULE17) zero chain id selects
    assign selected = (ctrl_byte[3:0] == 4'h0);

    // Daisy-chain pass-through
    chain_id_forward u_forward (
        .i_clk_sys            (i_clk_sys),
        .i_rst                (i_rst),
        .i_ce                 (i_ce),
        .i_ctrl_phase         (phase == chain_spi_pkg::PH_CTRL),
        .i_bit_cnt            (bit_cnt),
        .i_take               (sclk_rise & ~nss_s),
        .i_bit                (mosi_s),
        .i_mosi               (i_mosi),
        .o_serial_forward_out (o_serial_forward_out)
    );

    // Serial packet engine next state
    always_comb begin
        next_phase     = phase;
        next_bit_cnt   = bit_cnt;
        next_shift_in  = shift_in;
        next_ctrl_byte = ctrl_byte;
        next_tx_shift  = tx_shift;
        next_drive     = drive;
        next_mode0     = mode0;
        next_mode1     = mode1;
        next_dly0      = dly0;
        next_dly1      = dly1;
        next_lost_flag = lost_flag & ~clr_lost;
        next_addr_byte = addr_byte;
        if (!enable) begin
            next_phase   = chain_spi_pkg::PH_CTRL;
            next_bit_cnt = 4'h0;
            next_drive   = 1'b0;
        end else begin
            if (sclk_rise && nss_s) begin
                // (RULE6) resynchronise to control byte
                next_phase   = chain_spi_pkg::PH_CTRL;
                next_bit_cnt = 4'h0;
                next_drive   = 1'b0;
            end else if (sclk_rise) begin
                // (RULE2) (RULE22) shift in msb first
                next_shift_in = {shift_in[6:0], mosi_s};
                next_bit_cnt  = (bit_cnt >= chain_spi_pkg::BYTE_BITS) ?
                                chain_spi_pkg::BIT_CNT_OVER : bit_cnt + 4'h1;
            end
            if (sclk_fall && drive) begin
                next_tx_shift = {tx_shift[6:0], 1'b0};
            end
            // (RULE5) (RULE11) drive only for selected read
            if (nss_fall && phase == chain_spi_pkg::PH_DATA && is_read && selected) begin
                next_drive = 1'b1;
            end
            if (nss_rise) begin
                next_drive   = 1'b0;
                next_bit_cnt = 4'h0;
                if (bit_cnt == chain_spi_pkg::BYTE_BITS) begin
                    // (RULE3) (RULE1) (RULE21) advance byte
                    unique case (phase)
                        chain_spi_pkg::PH_CTRL: begin
                            next_ctrl_byte = shift_in;
                            next_phase     = chain_spi_pkg::PH_ADDR;
                        end
                        chain_spi_pkg::PH_ADDR: begin
                            next_addr_byte = shift_in;
                            next_phase     = chain_spi_pkg::PH_DATA;
                            // (RULE12) unmapped reads zero
                            unique case (shift_in)
                                chain_spi_pkg::SPI_CHAN_STATUS: next_tx_shift = status_s;
                                chain_spi_pkg::SPI_FILT_MODE0:  next_tx_shift = mode0;
                                chain_spi_pkg::SPI_FILT_MODE1:  next_tx_shift = mode1;
                                chain_spi_pkg::SPI_FILT_DLY0:   next_tx_shift = dly0;
                                chain_spi_pkg::SPI_FILT_DLY1:   next_tx_shift = dly1;
                                default:                        next_tx_shift = 8'h00;
                            endcase
                        end
                        chain_spi_pkg::PH_DATA: begin
                            // (RULE14) (RULE15) (RULE13) commit write
                            if (!is_read && (selected || ctrl_byte[chain_spi_pkg::CTRL_BCAST_BIT])) begin
                                unique case (addr_byte)
                                    chain_spi_pkg::SPI_FILT_MODE0: next_mode0 = shift_in;
                                    chain_spi_pkg::SPI_FILT_MODE1: next_mode1 = shift_in;
                                    chain_spi_pkg::SPI_FILT_DLY0:  next_dly0  = shift_in;
                                    chain_spi_pkg::SPI_FILT_DLY1:  next_dly1  = shift_in;
                                    default: ;
                                endcase
                            end
                            next_phase    = chain_spi_pkg::PH_CTRL;
                        end
                        chain_spi_pkg::PH_LOST: ;
                    endcase
                end else if (bit_cnt != 4'h0 && phase != chain_spi_pkg::PH_LOST) begin
                    // (RULE7) abandon packet, nothing written
                    next_phase     = chain_spi_pkg::PH_LOST;
                    next_lost_flag = 1'b1;
                end
            end
        end
    end

    // Register serial state; clock enable low freezes it
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            {nss_d, sclk_d} <= chain_spi_pkg::PIN_SYNC_RST[2:1];
            phase           <= chain_spi_pkg::PH_CTRL;
            {bit_cnt, shift_in, ctrl_byte, addr_byte, tx_shift, drive, lost_flag} <= '0;
            {mode0, mode1, dly0, dly1} <= {4{chain_spi_pkg::SPI_REG_RST}};
        end else if (i_ce) begin
            {nss_d, sclk_d} <= {nss_s, sclk_s};
            phase           <= next_phase;
            {bit_cnt, shift_in, ctrl_byte, addr_byte} <=
                {next_bit_cnt, next_shift_in, next_ctrl_byte, next_addr_byte};
            {tx_shift, drive, lost_flag} <= {next_tx_shift, next_drive, next_lost_flag};
            {mode0, mode1, dly0, dly1} <= {next_mode0, next_mode1, next_dly0, next_dly1};
        end
    end

    // Serial output pins and filter settings
    assign o_miso         = tx_shift[7];
    assign o_miso_oe_n    = ~drive;
    assign o_filter_mode  = {mode1, mode0};
    assign o_filter_delay = {dly1, dly0};

    // Bus takes address and data together; one write and one read in flight
    assign wr_go           = i_ce && i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid;
    assign o_s_axi_awready = wr_go;
    assign o_s_axi_wready  = wr_go;
    assign o_s_axi_arready = i_ce && !o_s_axi_rvalid;
    assign clr_lost        = wr_go && (i_s_axi_awaddr == chain_spi_pkg::AXI_STATUS)
                             && i_s_axi_wdata[chain_spi_pkg::STAT_LOST_BIT];

    // Bus responses and read decode
    always_comb begin
        next_enable = enable;
        next_bvalid = o_s_axi_bvalid && !i_s_axi_bready;
        next_bresp  = o_s_axi_bresp;
        next_rvalid = o_s_axi_rvalid && !i_s_axi_rready;
        next_rdata  = o_s_axi_rdata;
        next_rresp  = o_s_axi_rresp;
        if (wr_go) begin
            next_bvalid = 1'b1;
            next_bresp  = chain_spi_pkg::RESP_DECERR;
            if (i_s_axi_awaddr == chain_spi_pkg::AXI_STATUS) begin
                next_bresp = chain_spi_pkg::RESP_OKAY;
            end
            if (i_s_axi_awaddr == chain_spi_pkg::AXI_CTRL) begin
                next_bresp  = chain_spi_pkg::RESP_OKAY;
                next_enable = i_s_axi_wdata[chain_spi_pkg::CTRL_EN_BIT];
            end
        end
        if (i_s_axi_arvalid && o_s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = chain_spi_pkg::RESP_OKAY;
            unique case (i_s_axi_araddr)
                chain_spi_pkg::AXI_CTRL:   next_rdata = {31'h0, enable};
                chain_spi_pkg::AXI_STATUS: next_rdata = {22'h0, drive, lost_flag, status_s};
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = chain_spi_pkg::RESP_DECERR;
                end
            endcase
        end
    end

    // Register bus state
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            enable <= chain_spi_pkg::CTRL_EN_RST;
            {o_s_axi_bvalid, o_s_axi_bresp, o_s_axi_rvalid, o_s_axi_rdata, o_s_axi_rresp} <= '0;
        end else if (i_ce) begin
            enable <= next_enable;
            {o_s_axi_bvalid, o_s_axi_bresp, o_s_axi_rvalid, o_s_axi_rdata, o_s_axi_rresp} <=
                {next_bvalid, next_bresp, next_rvalid, next_rdata, next_rresp};
        end
    end

endmodule : chain_spi_target

`default_nettype wire

/* File: design/chain_spi_pkg.sv */
package chain_spi_pkg;

    // Serial framing
    localparam logic [3:0] BYTE_BITS      = 4'h8;
    localparam logic [3:0] BIT_CNT_OVER   = 4'h9;
    localparam logic [3:0] CID_FIRST_BIT  = 4'h4;
    localparam int         CTRL_BCAST_BIT = 7;
    localparam int         CTRL_READ_BIT  = 6;

    // Serial register addresses
    localparam logic [7:0] SPI_CHAN_STATUS = 8'h00;
    localparam logic [7:0] SPI_FILT_MODE0  = 8'h01;
    localparam logic [7:0] SPI_FILT_MODE1  = 8'h02;
    localparam logic [7:0] SPI_FILT_DLY0   = 8'h03;
    localparam logic [7:0] SPI_FILT_DLY1   = 8'h04;
    localparam logic [7:0] SPI_REG_RST     = 8'h00;

    // Register bus map
    localparam logic [7:0] AXI_CTRL       = 8'h00;
    localparam logic [7:0] AXI_STATUS     = 8'h04;
    localparam logic [7:0] AXI_COUNT      = 8'h08;
    localparam logic [5:0] AXI_MIRROR_LO  = 6'h04;
    localparam logic [5:0] AXI_MIRROR_HI  = 6'h08;
    localparam logic       CTRL_EN_RST    = 1'b1;
    localparam int         CTRL_EN_BIT    = 0;
    localparam int         STAT_LOST_BIT  = 8;
    localparam int         STAT_DRIVE_BIT = 9;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_DECERR    = 2'h3;

    // Synchroniser reset value for select, clock, data
    localparam logic [2:0] PIN_SYNC_RST   = 3'h4;

    // Packet phase
    typedef enum logic [1:0] {
        PH_CTRL = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b10,
        PH_LOST = 2'b11
    } phase_t;

endpackage : chain_spi_pkg

/* File: design/sync_2ff.sv */
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for signals from outside the clock domain
module sync_2ff #(
    parameter int            W       = 1,
    parameter logic [W-1:0]  RST_VAL = '0
) (
    // System
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    // Data
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    // Shift one stage per enabled cycle
    always_comb begin
        next_meta = i_ce ? i_async : meta;
        next_sync = i_ce ? meta : o_sync;
    end

    // Register both stages
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            meta   <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta   <= next_meta;
            o_sync <= next_sync;
        end
    end

endmodule : sync_2ff

`default_nettype wire

/* File: design/chain_id_forward.sv */
`timescale 1ns/100ps
`default_nettype none

// Pass-through of the serial input, decrementing the chain id bits
module chain_id_forward (
    // System
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    // Receiver state
    input  wire logic       i_ctrl_phase,
    input  wire logic [3:0] i_bit_cnt,
    input  wire logic       i_take,
    input  wire logic       i_bit,
    // Pins
    input  wire logic       i_mosi,
    output logic            o_serial_forward_out
);

    logic borrow;
    logic next_borrow;
    logic in_cid;

    assign in_cid = i_ctrl_phase && (i_bit_cnt >= chain_spi_pkg::CID_FIRST_BIT)
                    && (i_bit_cnt < chain_spi_pkg::BYTE_BITS);

    // (RULE18) serial borrow ripple
    always_comb begin
        next_borrow = 1'b1;
        if (in_cid) begin
            next_borrow = (i_take) ? (borrow & ~i_bit) : borrow;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            borrow <= 1'b1;
        end else if (i_ce) begin
            borrow <= next_borrow;
        end
    end

    // (RULE16) combinational pass-through
    assign o_serial_forward_out = i_mosi ^ (in_cid & borrow);

endmodule : chain_id_forward

`default_nettype wire

/* File: verification/chain_spi_target_properties.sv */
`timescale 1ns/100ps
`default_nettype none

// Port checks of the serial target and its register bus
module chain_spi_target_properties (
    // System
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    // Serial pins
    input wire logic        i_sclk,
    input wire logic        i_select_n,
    input wire logic        o_miso,
    input wire logic        o_miso_oe_n,
    // Register bus
    input wire logic        i_s_axi_awvalid,
    input wire logic        o_s_axi_awready,
    input wire logic        i_s_axi_arvalid,
    input wire logic        o_s_axi_arready,
    input wire logic        o_s_axi_bvalid,
    input wire logic        i_s_axi_bready,
    input wire logic [1:0]  o_s_axi_bresp,
    input wire logic        o_s_axi_rvalid,
    input wire logic        i_s_axi_rready,
    input wire logic [31:0] o_s_axi_rdata
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_miso_tristate: assert property (i_select_n [*6] |-> o_miso_oe_n)
        else $error("serial output driven while deselected");
    a_drive_in_frame: assert property ($fell(o_miso_oe_n) |-> !$past(i_select_n))
        else $error("serial output enabled outside a frame");
    a_miso_steady: assert property (i_sclk [*3] ##0 !o_miso_oe_n |-> $stable(o_miso))
        else $error("serial output changed while clock high");
    // Idle outputs after reset
    a_reset_idle: assert property ($fell(i_rst) |-> o_miso_oe_n && !o_s_axi_bvalid
                                  && !o_s_axi_rvalid)
        else $error("outputs not idle after reset");
    // Write response held until taken
    a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready
                                  |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response dropped before taken");
    // Read data held until taken
    a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
                                  |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data dropped before taken");
    // Write answered in bounded time
    a_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready
                                    |-> ##[0:32] o_s_axi_bvalid)
        else $error("write response missing");
    // Read answered in bounded time
    a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready
                                   |-> ##[0:32] o_s_axi_rvalid)
        else $error("read data missing");

    // Main scenarios reached
    c_serial_drive: cover property ($fell(o_miso_oe_n));
    c_write_done: cover property (o_s_axi_bvalid && i_s_axi_bready);
    c_read_done: cover property (o_s_axi_rvalid && i_s_axi_rready);
endmodule : chain_spi_target_properties

`default_nettype wire

/* File: verification/spi_master_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Serial master: frames bytes with select, clock idles low between frames
module spi_master_model (
    // Serial pins
    output logic            o_sclk,
    output logic            o_select_n,
    output logic            o_mosi,
    input  wire logic       i_miso,
    input  wire logic       i_miso_oe_n,
    input  wire logic       i_forward
);
    localparam time HALF = 400ns;

    // Idle pins at time zero
    initial begin
        o_sclk     = 1'b0;
        o_select_n = 1'b1;
        o_mosi     = 1'b0;
    end

    // One framed byte, msb first; nbits other than 8 corrupts it
    task automatic frame(input logic [7:0] tx, input int nbits, output logic [7:0] rx,
                         output logic [7:0] fw, output logic dv);
        dv         = 1'b0;
        o_select_n = 1'b0;
        for (int b = 0; b < nbits; b++) begin
            o_mosi = tx[7 - (b % 8)];
            #HALF;
            fw = {fw[6:0], i_forward};
            rx = {rx[6:0], i_miso};
            if (i_miso_oe_n !== 1'b1) dv = 1'b1;
            o_sclk = 1'b1;
            #HALF;
            o_sclk = 1'b0;
        end
        #HALF;
        o_select_n = 1'b1;
        o_mosi     = ~o_mosi; // Released line shows the inverse
        #HALF;
    endtask : frame

    task automatic resync();
        #HALF;
        o_sclk = 1'b1;
        #HALF;
        o_sclk = 1'b0;
        #HALF;
    endtask : resync
endmodule : spi_master_model

`default_nettype wire

/* File: verification/daisy_chain_spi_target_tb.sv */
`timescale 1ns/100ps
`default_nettype none

// Bench: serial master partner, register bus master, reference register model
module daisy_chain_spi_target_tb;
    // Clock, reset, pins
    logic        i_clk_sys = 1'b0;
    logic        i_rst     = 1'b1;
    logic [7:0]  status    = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr  = 8'h00, araddr = 8'h00;
    logic [31:0] wdata   = 32'h0, rd;
    logic        sclk, select_n, mosi, awready, wready, bvalid, arready, rvalid;
    logic        miso, miso_oe_n, fwd_out;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata;
    logic [7:0]  regs [1:4];
    int          num_errors = 0;
    int          checks     = 0;

    // Clock of 100 ns
    always #50 i_clk_sys = ~i_clk_sys;

    chain_spi_target uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(1'b1),
        .i_sclk(sclk), .i_select_n(select_n), .i_mosi(mosi), .o_miso(miso),
        .o_miso_oe_n(miso_oe_n), .o_serial_forward_out(fwd_out), .i_channel_status(status),
        .o_filter_mode(), .o_filter_delay(), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
        .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp));

    spi_master_model master (.o_sclk(sclk), .o_select_n(select_n), .o_mosi(mosi),
        .i_miso(miso), .i_miso_oe_n(miso_oe_n), .i_forward(fwd_out));

    // Verdict and end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    // Compare and count
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // Register bus transfer; handshakes seen at negedge complete at next posedge
    task automatic axi(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        logic aw_hit, w_hit, done;
        int   n;
        @(posedge i_clk_sys);
        awvalid <= wr;
        wvalid  <= wr;
        awaddr  <= addr;
        wdata   <= data;
        bready  <= wr;
        arvalid <= !wr;
        araddr  <= addr;
        rready  <= !wr;
        n = 0;
        do begin
            @(negedge i_clk_sys);
            aw_hit = awvalid && awready;
            w_hit  = wvalid && wready;
            done   = wr ? (bvalid === 1'b1) : (rvalid === 1'b1);
            resp   = wr ? bresp : rresp;
            rd     = rdata;
            @(posedge i_clk_sys);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
        end while (!done && n < 200);
        bready <= 1'b0;
        rready <= 1'b0;
        cmp("bus answer", 8'h01, {7'h00, done});
    endtask : axi

    // Expected serial read value
    function automatic logic [7:0] exp_read(input logic [7:0] a);
        if (a == chain_spi_pkg::SPI_CHAN_STATUS) return status;
        if (a >= 8'h01 && a <= 8'h04) return regs[a[2:0]];
        return 8'h00;
    endfunction : exp_read

    // Three-byte packet; nd bits in the data byte, short means abandoned
    task automatic packet(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
                          input int nd);
        logic [7:0] rx, fw;
        logic       dv, hit;
        logic [3:0] id, nid;
        id  = {c[0], c[1], c[2], c[3]};
        nid = id - 4'h1;
        hit = (id == 4'h0);
        master.frame(c, 8, rx, fw, dv);
        cmp("forward control", {c[7:4], nid[0], nid[1], nid[2], nid[3]}, fw);
        cmp("drive control", 8'h00, {7'h00, dv});
        master.frame(a, 8, rx, fw, dv);
        cmp("forward address", a, fw);
        master.frame(d, nd, rx, fw, dv);
        if (nd < 8) begin
            master.resync();
        end else begin
            cmp("forward data", d, fw);
            cmp("drive data", {7'h00, c[6] & hit}, {7'h00, dv});
            if (c[6] && hit) cmp("read data", exp_read(a), rx);
            if (!c[6] && (c[7] || hit) && a >= 8'h01 && a <= 8'h04) regs[a[2:0]] = d;
        end
    endtask : packet

    // Main sequence
    initial begin
        logic [7:0] rx, fw;
        logic       dv;
        rd = $urandom(32'ha2872035);
        for (int i = 1; i <= 4; i++) regs[i] = chain_spi_pkg::SPI_REG_RST;
        repeat (3) @(posedge i_clk_sys);
        i_rst  <= 1'b0;
        status <= 8'($urandom());
        axi(1'b1, chain_spi_pkg::AXI_CTRL, 32'h1);
        cmp("ctrl resp", {6'h00, chain_spi_pkg::RESP_OKAY}, {6'h00, resp});
        axi(1'b0, chain_spi_pkg::AXI_STATUS, 32'h0);
        cmp("status resp", {6'h00, chain_spi_pkg::RESP_OKAY}, {6'h00, resp});
        axi(1'b0, 8'hfc, 32'h0);
        cmp("unmapped resp", {6'h00, chain_spi_pkg::RESP_DECERR}, {6'h00, resp});
        $display("test register bus done");
        #37;
        for (int a = 0; a < 6; a++) packet(8'h40, 8'(a), 8'h00, 8);
        $display("test reset values done");
        repeat (40) begin
            rx = 8'($urandom() % 16);
            if ($urandom() % 3 != 0) rx = 8'h00;
            packet({2'($urandom()), 2'b00, rx[3:0]}, 8'($urandom() % 7), 8'($urandom()), 8);
        end
        $display("test random packets done");
        packet(8'h00, 8'h02, ~regs[2], 5);
        master.frame(8'h00, 8, rx, fw, dv);
        master.frame(8'h03, 4, rx, fw, dv);
        master.resync();
        packet(8'h40, 8'h02, 8'h00, 8);
        packet(8'h40, 8'h03, 8'h00, 8);
        packet(8'h00, 8'h03, 8'h5a, 8);
        packet(8'hc0, 8'h03, 8'h00, 8);
        $display("test abandon and resync done");
        give_verdict();
    end

    // Watchdog
    initial begin
        #5ms;
        num_errors++;
        $display("[ERR] watchdog expected finish seen hang");
        give_verdict();
    end
endmodule : daisy_chain_spi_target_tb

bind chain_spi_target chain_spi_target_properties props (.*);

`default_nettype wire
